// *** verilog/scd_front_end.sv ***
// State capture front end with demultiplexer, trace FIFO and APB registers
`timescale 1ns/1ps

// ********************************
// Trace FIFO
// ********************************
module scd_fifo
	import scd_pkg::*;
#(
	parameter int W = 8,
	parameter int D = 16
)
(
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data,
	output logic [$clog2(D+1)-1:0] level
);
	localparam int PW = $clog2(D);
	localparam int CW = $clog2(D+1);
	typedef struct packed {
		logic [D-1:0][W-1:0] mem; // Storage words
		logic [PW-1:0] wp; // Write index
		logic [PW-1:0] rp; // Read index
		logic [CW-1:0] cnt; // Fill level
	} scd_fifo_s;
	scd_fifo_s st;
	scd_fifo_s next_st;
	logic push;
	logic pop;

	// Flags come from the count, so full and empty are exact
	assign in_ready = (st.cnt != CW'(D));
	assign out_valid = (st.cnt != '0);
	assign out_data = st.mem[st.rp];
	assign level = st.cnt;
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// Next state of storage and pointers
	always_comb
	begin
		next_st = st;
		if (push)
		begin
			next_st.mem[st.wp] = in_data;
			next_st.wp = (st.wp == PW'(D - 1)) ? '0 : st.wp + 1'b1;
		end
		if (pop)
			next_st.rp = (st.rp == PW'(D - 1)) ? '0 : st.rp + 1'b1;
		next_st.cnt = st.cnt + CW'(push) - CW'(pop);
	end

	// Register with synchronous reset and clock enable
	always_ff @(posedge clock)
	begin
		if (rst)
			st <= '0; // Empty, both indexes on the first word
		else if (ce)
			st <= next_st;
	end
endmodule

// ********************************
// Capture front end top
// ********************************
module scd_front_end
	import scd_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [2:0] target_clk,
	input wire logic [CH_W-1:0] probe_data,
	input wire logic [POD_N-1:0] pod_connected,
	output logic [31:0] threshold_code
);
	typedef struct packed {
		logic [2:0] ck1; // Clock sync first stage
		logic [2:0] ck2; // Clock sync second stage
		logic [2:0] ck3; // Previous clock level
		logic [CH_W-1:0] d1; // Probe sync first stage
		logic [CH_W-1:0] d2; // Probe sync second stage
		logic [POD_N-1:0] pc1; // Connection sync first stage
		logic [POD_N-1:0] pc2; // Connection sync second stage
		scd_seq_e sq; // Trace sequencer
		logic [1:0] trig; // Trigger mode
		logic qual_en; // Store only term 0 matches
		logic restart_en; // Sequence restart enable
		logic [1:0] mux; // Demux ratio
		logic [1:0] base; // Listing number base
		logic [5:0] m_edge; // Master edges {fall,rise} x3
		logic [5:0] s_edge; // Slave edges
		logic [POD_N-1:0] pods; // Pods routed to state capture
		logic [POD_N-1:0] lbl_up; // upper_pods_label_group
		logic [POD_N-1:0] lbl_lo; // lower_pods_label_group
		logic [31:0] t0p; // Term 0 pattern
		logic [31:0] t0m; // Term 0 mask
		logic [31:0] t1p; // Term 1 pattern
		logic [31:0] t1m; // Term 1 mask
		logic [31:0] thr; // Pod threshold codes
		logic [CH_W-1:0] hold; // Demux holding register
		logic [31:0] rd; // Read data
		logic rdy; // Access answer
		logic err; // Unmapped access
	} scd_st_s;
	scd_st_s st;
	scd_st_s next_st;
	logic f_in_valid;
	logic f_in_ready;
	logic [CH_W-1:0] f_in_data;
	logic f_out_valid;
	logic f_out_ready;
	logic [CH_W-1:0] f_out_data;
	logic [LVL_W-1:0] f_level;
	logic m_hit; // Master edge seen this cycle
	logic s_hit; // Slave edge seen this cycle
	logic smp; // Sample offered to the sequencer
	logic done_acc; // APB access completes at this edge
	logic [CH_W-1:0] cap; // Synced probes after pod gating
	logic [CH_W-1:0] tot; // Channels recorded in this mode
	logic [CH_W-1:0] smsk; // Channels owned by the slave clock
	logic [CH_W-1:0] ent; // Entry offered to trace memory
	logic [CH_W-1:0] shown; // Oldest entry seen through the labels

	// Widen a pod mask to one bit per channel
	function automatic logic [CH_W-1:0] pod_expand(input logic [POD_N-1:0] p);
		logic [CH_W-1:0] m;
		m = '0;
		for (int i = 0; i < CH_W; i++)
			m[i] = p[i / POD_W];
		return m;
	endfunction

	// Any selected edge among the three clocks
	function automatic logic edge_hit(input logic [5:0] sel, input logic [2:0] now,
		input logic [2:0] old);
		logic h;
		h = 1'b0;
		for (int i = 0; i < 3; i++)
			h = h | (sel[2*i] & now[i] & ~old[i]) | (sel[2*i+1] & ~now[i] & old[i]);
		return h;
	endfunction

	// Resource term compare on the low channels
	function automatic logic term_hit(input logic [CH_W-1:0] d, input logic [31:0] p,
		input logic [31:0] m);
		return (((d[31:0] ^ p) & m) == 32'h0000_0000);
	endfunction

	// Trace FIFO stands between capture and readout
	scd_fifo #(.W(CH_W), .D(FIFO_D)) u_fifo (
		.clock(clock),
		.rst(rst),
		.ce(ce),
		.in_valid(f_in_valid),
		.in_ready(f_in_ready),
		.in_data(f_in_data),
		.out_valid(f_out_valid),
		.out_ready(f_out_ready),
		.out_data(f_out_data),
		.level(f_level)
	);

	assign prdata = st.rd;
	assign pready = st.rdy;
	assign pslverr = st.err;
	assign threshold_code = st.thr;

	// Capture, sequencing and register access
	always_comb
	begin
		next_st = st;
		f_in_valid = 1'b0;
		f_out_ready = 1'b0;
		// Two flops before any logic reads a pin
		next_st.ck1 = target_clk;
		next_st.ck2 = st.ck1;
		next_st.ck3 = st.ck2;
		next_st.d1 = probe_data;
		next_st.d2 = st.d1;
		next_st.pc1 = pod_connected;
		next_st.pc2 = st.pc1;
		// Absent probes and timing pods read as zero
		cap = st.d2 & pod_expand(st.pc2 & st.pods);
		m_hit = edge_hit(st.m_edge, st.ck2, st.ck3);
		s_hit = edge_hit(st.s_edge, st.ck2, st.ck3);
		// Channel split per ratio
		if (st.mux == MUX_27_16)
		begin
			tot = MSK_43;
			smsk = MSK_27;
		end
		else if (st.mux == MUX_27_38)
		begin
			tot = ONES;
			smsk = MSK_27;
		end
		else if (st.mux == MUX_18_38)
		begin
			tot = MSK_56;
			smsk = MSK_18;
		end
		else
		begin
			tot = ONES;
			smsk = '0;
		end
		// Slave edge only loads holding; trace memory untouched
		if (st.mux != MUX_OFF && s_hit)
			next_st.hold = cap & smsk;
		// Master edge merges holding with master channels
		ent = tot & ((st.hold & smsk) | (cap & ~smsk));
		smp = m_hit;
		f_in_data = ent;
		// Trace sequencer
		case (st.sq)
			SQ_WAIT_T0:
			begin
				if (smp && term_hit(ent, st.t0p, st.t0m))
					next_st.sq = SQ_WAIT_T1;
			end
			SQ_WAIT_T1:
			begin
				if (smp && term_hit(ent, st.t1p, st.t1m))
					next_st.sq = SQ_STORE;
				else if (smp && st.restart_en && st.trig == TRIG_SEQ
					&& !term_hit(ent, st.t0p, st.t0m))
					next_st.sq = SQ_WAIT_T0;
			end
			SQ_STORE:
			begin
				// Full trace memory ends the single run
				if (!f_in_ready)
					next_st.sq = SQ_DONE;
				else if (smp && (!st.qual_en || term_hit(ent, st.t0p, st.t0m)))
					f_in_valid = 1'b1;
			end
			default:
				next_st.sq = st.sq;
		endcase
		// APB answers one cycle into the access phase
		next_st.rdy = 1'b0;
		next_st.err = 1'b0;
		done_acc = psel & penable & st.rdy;
		shown = f_out_data & pod_expand(st.lbl_up | st.lbl_lo);
		if (psel && penable && !st.rdy)
		begin
			next_st.rdy = 1'b1;
			next_st.rd = 32'h0000_0000;
			// Busy in bit 0, done in bit 2, setup echoed above them
			if (paddr == A_CTRL)
				next_st.rd = {24'h00_0000, st.restart_en, st.qual_en, st.trig, 1'b0,
					(st.sq == SQ_DONE), 1'b0, (st.sq != SQ_IDLE && st.sq != SQ_DONE)};
			else if (paddr == A_MUX)
				next_st.rd = {26'h000_0000, st.base, 2'h0, st.mux};
			else if (paddr == A_CLK)
				next_st.rd = {18'h0_0000, st.s_edge, 2'h0, st.m_edge};
			else if (paddr == A_PODS)
				next_st.rd[POD_N-1:0] = st.pods;
			else if (paddr == A_LABEL)
				next_st.rd = {7'h00, st.lbl_lo, 7'h00, st.lbl_up};
			else if (paddr == A_T0P)
				next_st.rd = st.t0p;
			else if (paddr == A_T0M)
				next_st.rd = st.t0m;
			else if (paddr == A_T1P)
				next_st.rd = st.t1p;
			else if (paddr == A_T1M)
				next_st.rd = st.t1m;
			else if (paddr == A_THR)
				next_st.rd = st.thr;
			else if (paddr == A_DAT0)
				next_st.rd = shown[31:0];
			else if (paddr == A_DAT1)
				next_st.rd = shown[63:32];
			else if (paddr == A_DAT2)
				next_st.rd[0] = shown[64];
			else if (paddr == A_STAT)
				next_st.rd = {23'h00_0000, f_out_valid, 3'h0, f_level};
			else
				next_st.err = 1'b1;
		end
		// Writes and read side effects at the completing edge
		if (done_acc && !pwrite && paddr == A_DAT2)
			f_out_ready = 1'b1;
		if (done_acc && pwrite)
		begin
			if (paddr == A_CTRL)
			begin
				next_st.trig = pwdata[5:4];
				next_st.qual_en = pwdata[6];
				next_st.restart_en = pwdata[7];
				if (pwdata[1])
					next_st.sq = SQ_IDLE;
				else if (pwdata[0])
				begin
					if (pwdata[5:4] == TRIG_SEQ)
						next_st.sq = SQ_WAIT_T0;
					else if (pwdata[5:4] == TRIG_SIMPLE)
						next_st.sq = SQ_WAIT_T1;
					else
						next_st.sq = SQ_STORE;
				end
			end
			else if (paddr == A_MUX)
			begin
				next_st.mux = pwdata[1:0];
				next_st.base = pwdata[5:4];
				// Turning demux on loads default edges
				if (st.mux == MUX_OFF && pwdata[1:0] != MUX_OFF)
				begin
					next_st.m_edge = EDGE_M_DEF;
					next_st.s_edge = EDGE_S_DEF;
				end
			end
			else if (paddr == A_CLK)
			begin
				next_st.m_edge = pwdata[5:0];
				next_st.s_edge = pwdata[13:8];
			end
			else if (paddr == A_PODS)
				next_st.pods = pwdata[POD_N-1:0];
			else if (paddr == A_LABEL)
			begin
				next_st.lbl_up = pwdata[POD_N-1:0];
				next_st.lbl_lo = pwdata[16 +: POD_N];
			end
			else if (paddr == A_T0P)
				next_st.t0p = pwdata;
			else if (paddr == A_T0M)
				next_st.t0m = pwdata;
			else if (paddr == A_T1P)
				next_st.t1p = pwdata;
			else if (paddr == A_T1M)
				next_st.t1m = pwdata;
			else if (paddr == A_THR)
				next_st.thr = pwdata;
		end
	end

	// State register; reset loads the power-up configuration
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			st <= '0; // Idle, free run, demux off, terms and threshold clear
			st.m_edge <= EDGE_M_DEF;
			st.base <= BASE_HEX;
			st.pods <= PODS_ALL;
			st.lbl_up <= LBL_UP_DEF;
			st.lbl_lo <= LBL_LO_DEF;
		end
		else if (ce)
			st <= next_st;
	end
endmodule

// *** verilog/scd_pkg.sv ***
// Constants, types and register map of the state capture front end
package scd_pkg;
	// ********************************
	// Widths
	// ********************************
	localparam int CH_W = 65;
	localparam int POD_N = 9;
	localparam int POD_W = 8;
	localparam int FIFO_D = 16;
	localparam int LVL_W = 5;
	localparam int ADDR_W = 8;
	// ********************************
	// Register byte offsets
	// ********************************
	localparam logic [ADDR_W-1:0] A_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] A_MUX = 8'h04;
	localparam logic [ADDR_W-1:0] A_CLK = 8'h08;
	localparam logic [ADDR_W-1:0] A_PODS = 8'h0C;
	localparam logic [ADDR_W-1:0] A_LABEL = 8'h10;
	localparam logic [ADDR_W-1:0] A_T0P = 8'h14;
	localparam logic [ADDR_W-1:0] A_T0M = 8'h18;
	localparam logic [ADDR_W-1:0] A_T1P = 8'h1C;
	localparam logic [ADDR_W-1:0] A_T1M = 8'h20;
	localparam logic [ADDR_W-1:0] A_THR = 8'h24;
	localparam logic [ADDR_W-1:0] A_DAT0 = 8'h28;
	localparam logic [ADDR_W-1:0] A_DAT1 = 8'h2C;
	localparam logic [ADDR_W-1:0] A_DAT2 = 8'h30;
	localparam logic [ADDR_W-1:0] A_STAT = 8'h34;
	// ********************************
	// Reset values and codes
	// ********************************
	localparam logic [5:0] EDGE_M_DEF = 6'h01;
	localparam logic [5:0] EDGE_S_DEF = 6'h02;
	localparam logic [1:0] MUX_OFF = 2'h0;
	localparam logic [1:0] MUX_27_16 = 2'h1;
	localparam logic [1:0] MUX_27_38 = 2'h2;
	localparam logic [1:0] MUX_18_38 = 2'h3;
	localparam logic [1:0] BASE_HEX = 2'h0;
	localparam logic [1:0] TRIG_FREE = 2'h0;
	localparam logic [1:0] TRIG_SIMPLE = 2'h1;
	localparam logic [1:0] TRIG_SEQ = 2'h2;
	localparam logic [POD_N-1:0] PODS_ALL = 9'h1FF;
	localparam logic [POD_N-1:0] LBL_UP_DEF = 9'h070;
	localparam logic [POD_N-1:0] LBL_LO_DEF = 9'h007;
	localparam logic [CH_W-1:0] ONES = {CH_W{1'b1}};
	localparam logic [CH_W-1:0] MSK_43 = ONES >> (CH_W - 43);
	localparam logic [CH_W-1:0] MSK_56 = ONES >> (CH_W - 56);
	localparam logic [CH_W-1:0] MSK_27 = ONES >> (CH_W - 27);
	localparam logic [CH_W-1:0] MSK_18 = ONES >> (CH_W - 18);
	typedef enum logic [2:0] {SQ_IDLE, SQ_WAIT_T0, SQ_WAIT_T1, SQ_STORE, SQ_DONE} scd_seq_e;
endpackage

// *** verif/scd_front_end_checker.sv ***
// Checker of the front end's register bus and threshold port
`timescale 1ns/1ps
module scd_front_end_checker
	import scd_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] threshold_code
);
	// ********************************
	// Helper logic
	// ********************************
	logic [31:0] thr_last; // Last threshold word accepted
	wire thr_wr = psel && penable && pwrite && pready && paddr == A_THR; // Write edge
	// Remember the word, since the master drops it after the edge
	always_ff @(posedge clock)
	begin
		if (thr_wr)
		begin
			thr_last <= pwdata;
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	// ********************************
	// Assertions
	// ********************************
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held past one cycle");
	chk_ready_wait: assert property (ce && psel && penable && !pready |=> pready)
		else $error("pready late");
	chk_setup_quiet: assert property (psel && !penable |=> !pready)
		else $error("pready after setup only");
	chk_ready_cause: assert property (pready |-> $past(psel && penable && !pready))
		else $error("pready without access");
	chk_err_zero: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
		else $error("error response malformed");
	chk_thr_follow: assert property (thr_wr |=> ##[0:1] threshold_code == thr_last)
		else $error("threshold code not updated");
	chk_thr_hold: assert property ($changed(threshold_code) && !$past(rst)
		&& !$past(rst, 2) |-> $past(thr_wr) || $past(thr_wr, 2))
		else $error("threshold code moved alone");
	chk_reset_clear: assert property ($past(rst) |-> !pready && !pslverr && prdata == 32'h0000_0000
		&& threshold_code == 32'h0000_0000)
		else $error("outputs not cleared by reset");
endmodule
bind scd_front_end scd_front_end_checker i_chk (.clock(clock), .rst(rst), .ce(ce),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .threshold_code(threshold_code));

// *** verif/scd_target.sv ***
// Behavioural target bus driving probe channels and three clocks
`timescale 1ns/1ps
module scd_target
	import scd_pkg::*;
(
	output logic [2:0] target_clk,
	output logic [CH_W-1:0] probe_data,
	output logic [POD_N-1:0] pod_connected
);
	// Clocks stand still low between transfers
	initial
	begin
		target_clk = 3'h0;
		probe_data = '0;
		pod_connected = PODS_ALL;
	end
	// Pods with a probe attached
	task automatic set_conn(input logic [POD_N-1:0] p);
		pod_connected = p;
	endtask
	// One 125 ns period on clock c; data steady across both edges
	task automatic pulse(input int c, input logic [CH_W-1:0] d);
		probe_data = d;
		#31.25;
		target_clk[c] = 1'b1;
		#62.5;
		target_clk[c] = 1'b0;
		#31.25;
		// Released bus shows the inverse, never the stale value
		probe_data = ~d;
	endtask
endmodule

// *** verif/test_scd_front_end.sv ***
// Self-checking bench of the state capture front end
`timescale 1ns/1ps
module test_scd_front_end
	import scd_pkg::*;
;
	// ********************************
	// Signals
	// ********************************
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic ce = 1'b1;
	logic [31:0] prdata;
	logic [31:0] threshold_code;
	logic pready;
	logic pslverr;
	wire [2:0] target_clk;
	wire [CH_W-1:0] probe_data;
	wire [POD_N-1:0] pod_connected;
	int bad_count = 0;
	int tests_run = 0;
	logic [CH_W-1:0] lm; // Channels inside the default label groups
	always #2 clock = ~clock;
	scd_front_end i_dut (.clock(clock), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .target_clk(target_clk), .probe_data(probe_data),
		.pod_connected(pod_connected), .threshold_code(threshold_code));
	scd_target i_tgt (.target_clk(target_clk), .probe_data(probe_data),
		.pod_connected(pod_connected));
	// ********************************
	// Shared tasks
	// ********************************
	task automatic check(input string n, input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", n, exp, got);
		end
	endtask
	// One APB transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			check("pready", 32'h0000_0000, 32'h0000_0001);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] x, input string n);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0000_0000, r, e);
		check(n, r, x);
	endtask
	// Reading the top word pops the entry, so order matters
	task automatic ent(input logic [CH_W-1:0] x);
		rdc(A_DAT0, x[31:0], "dat0");
		rdc(A_DAT1, x[63:32], "dat1");
		rdc(A_DAT2, {31'h0000_0000, x[64]}, "dat2");
	endtask
	function automatic logic [CH_W-1:0] pm(input logic [POD_N-1:0] p);
		for (int i = 0; i < CH_W; i++)
			pm[i] = p[i/8];
	endfunction
	// Demux entry: master part over held slave part, seen through labels
	function automatic logic [CH_W-1:0] mx(input logic [CH_W-1:0] m, input logic [CH_W-1:0] s);
		mx = ((m & ~MSK_27) | (s & MSK_27)) & lm;
	endfunction
	// Demux entry for any split: slave part from s, master part from m
	function automatic logic [CH_W-1:0] mxs(input logic [CH_W-1:0] m, input logic [CH_W-1:0] s,
		input logic [CH_W-1:0] sm, input logic [CH_W-1:0] tm);
		mxs = ((m & ~sm) | (s & sm)) & tm & lm;
	endfunction
	task automatic do_reset();
		rst <= 1'b1;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// ********************************
	// Scenarios
	// ********************************
	task automatic t_regs();
		logic [31:0] r;
		logic e;
		do_reset();
		rdc(A_CLK, 32'h0000_0001, "clk");
		rdc(A_PODS, 32'h0000_01FF, "pods");
		rdc(A_LABEL, 32'h0007_0070, "label");
		rdc(A_MUX, 32'h0000_0000, "mux");
		for (int m = 0; m < 4; m++)
		begin
			wr(A_MUX, 32'(m));
			rdc(A_MUX, 32'(m), "mode");
		end
		apb(1'b0, 8'h3C, 32'h0000_0000, r, e);
		check("err", {31'h0000_0000, e}, 32'h0000_0001);
		wr(A_THR, 32'h0000_0A5C);
		repeat (2) @(posedge clock);
		check("thr", threshold_code, 32'h0000_0A5C);
		$display("regs done");
	endtask
	task automatic t_default();
		logic [CH_W-1:0] d;
		d = 65'h1_2345_6789_ABCD_EF01;
		do_reset();
		i_tgt.set_conn(9'h1FB);
		wr(A_CTRL, 32'h0000_0001);
		i_tgt.pulse(1, ~d);
		i_tgt.pulse(0, d);
		rdc(A_STAT, 32'h0000_0101, "stat");
		ent(d & lm & pm(9'h1FB));
		// Narrow the labels to pods 0 and 1; readout follows them
		wr(A_LABEL, 32'h0000_0003);
		i_tgt.pulse(0, d);
		ent(d & pm(9'h003));
		i_tgt.set_conn(PODS_ALL);
		$display("default done");
	endtask
	task automatic t_demux();
		logic [CH_W-1:0] a;
		logic [CH_W-1:0] b;
		logic [CH_W-1:0] c;
		a = 65'h1_5555_5555_5555_5555;
		b = 65'h0_AAAA_AAAA_AAAA_AAAA;
		c = 65'h1_3C3C_3C3C_3C3C_3C3C;
		do_reset();
		wr(A_MUX, 32'h0000_0002);
		rdc(A_CLK, 32'h0000_0201, "clk");
		// Defaults put both roles on the primary clock; move the slave to clock 1
		wr(A_CLK, 32'h0000_0401);
		rdc(A_CLK, 32'h0000_0401, "clk");
		wr(A_CTRL, 32'h0000_0001);
		i_tgt.pulse(1, a);
		rdc(A_STAT, 32'h0000_0000, "stat");
		i_tgt.pulse(0, b);
		i_tgt.pulse(0, c);
		ent(mx(b, a));
		ent(mx(c, a));
		wr(A_CLK, 32'h0000_0104);
		rdc(A_CLK, 32'h0000_0104, "clk");
		i_tgt.pulse(0, c);
		i_tgt.pulse(1, b);
		ent(mx(b, c));
		$display("demux done");
	endtask
	task automatic t_edges();
		do_reset();
		wr(A_CLK, 32'h0000_0018);
		wr(A_CTRL, 32'h0000_0001);
		i_tgt.pulse(0, '0);
		rdc(A_STAT, 32'h0000_0000, "stat");
		i_tgt.pulse(1, '1);
		rdc(A_STAT, 32'h0000_0101, "stat");
		i_tgt.pulse(2, '1);
		rdc(A_STAT, 32'h0000_0102, "stat");
		// A pulse while frozen must leave no edge behind
		ce <= 1'b0;
		i_tgt.pulse(2, '1);
		@(posedge clock);
		ce <= 1'b1;
		rdc(A_STAT, 32'h0000_0102, "frozen");
		$display("edges done");
	endtask
	task automatic t_trig();
		do_reset();
		wr(A_T0P, 32'h0000_0011);
		wr(A_T0M, 32'h0000_00FF);
		wr(A_T1P, 32'h0000_0022);
		wr(A_T1M, 32'h0000_00FF);
		// Sequence with restart and store qualification
		wr(A_CTRL, 32'h0000_00E1);
		rdc(A_CTRL, 32'h0000_00E1, "ctrl");
		i_tgt.pulse(0, 65'h22);
		i_tgt.pulse(0, 65'h11);
		i_tgt.pulse(0, 65'h33);
		i_tgt.pulse(0, 65'h22);
		i_tgt.pulse(0, 65'h11);
		rdc(A_STAT, 32'h0000_0000, "restart");
		i_tgt.pulse(0, 65'h22);
		i_tgt.pulse(0, 65'h55);
		i_tgt.pulse(0, 65'h11);
		rdc(A_STAT, 32'h0000_0101, "qualify");
		ent(65'h11);
		// Simple trigger waits for term 1 only and stores what follows
		wr(A_CTRL, 32'h0000_0011);
		i_tgt.pulse(0, 65'h11);
		i_tgt.pulse(0, 65'h22);
		i_tgt.pulse(0, 65'h44);
		ent(65'h44);
		// Free run fills trace memory once and stops
		wr(A_CTRL, 32'h0000_0001);
		for (int i = 0; i < FIFO_D + 1; i++)
			i_tgt.pulse(0, 65'(i));
		rdc(A_CTRL, 32'h0000_0004, "done");
		rdc(A_STAT, 32'h0000_0100 | 32'(FIFO_D), "full");
		wr(A_CTRL, 32'h0000_0002);
		rdc(A_CTRL, 32'h0000_0000, "stop");
		$display("trigger done");
	endtask
	task automatic t_modes();
		logic [CH_W-1:0] a;
		logic [CH_W-1:0] b;
		a = 65'h1_5555_5555_5555_5555;
		b = 65'h0_AAAA_AAAA_AAAA_AAAA;
		do_reset();
		// Default edges: master on primary rise, slave on its fall
		wr(A_MUX, 32'h0000_0001);
		wr(A_CTRL, 32'h0000_0001);
		i_tgt.pulse(0, a);
		i_tgt.pulse(0, b);
		ent(mxs(a, '0, MSK_27, MSK_43));
		ent(mxs(b, a, MSK_27, MSK_43));
		// Eighteen slave channels for a sixteen-bit bus
		wr(A_MUX, 32'h0000_0003);
		i_tgt.pulse(0, a);
		i_tgt.pulse(0, b);
		ent(mxs(a, b, MSK_18, MSK_56));
		ent(mxs(b, a, MSK_18, MSK_56));
		$display("modes done");
	endtask
	// ********************************
	// Main sequence and watchdog
	// ********************************
	initial
	begin
		lm = pm(LBL_UP_DEF | LBL_LO_DEF);
		t_regs();
		t_default();
		t_demux();
		t_edges();
		t_trig();
		t_modes();
		print_verdict();
	end
	// Whole run needs well under a tenth of this
	initial
	begin
		#200000;
		bad_count++;
		print_verdict();
	end
endmodule
